// ==== include/pin_function_select_regs.svh ====
// Offsets, field positions and reset values of the pin-select registers
//
// Overview of operation
// R1 - Field 19:16 of word two routes lane-3 pin
// R2 - Field 15:12 of word two routes lane-4 pin
// R3 - Field 11:8 of word two routes lane-5 pin
// R4 - Field 7:4, code zero selects realtime input six
// R5 - Field 3:0, code zero selects realtime input seven
// R6 - Word three 31:28, zero selects cold presence detect
// R7 - Word three 27:24, zero selects mech presence switch
// R8 - Word three 23:20 routes chip select four pin
// R9 - Word three 19:16 routes chip select five pin
// R10 - Word three fields read/write, reset to zero
// R11 - Reserved codes keep the pin tri-stated
// R12 - New selection drives pin one cycle later
`ifndef PIN_FUNCTION_SELECT_REGS_SVH
`define PIN_FUNCTION_SELECT_REGS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_SEL2_WORD 12'h008
`define OFS_SEL3_WORD 12'h00C
`define OFS_SEL_STATUS 12'h010

// ----------------------------------------------------------------
// Field positions (least significant bit of each 4-bit field)
// ----------------------------------------------------------------
`define SEL_FIELD_W 4
`define SEL2_19_16_LSB 16
`define SEL2_15_12_LSB 12
`define SEL2_11_8_LSB 8
`define SEL2_7_4_LSB 4
`define SEL2_3_0_LSB 0
`define SEL3_31_28_LSB 28
`define SEL3_27_24_LSB 24
`define SEL3_23_20_LSB 20
`define SEL3_19_16_LSB 16

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SEL_FIELD_RST 4'h0
`define SEL_WORD_RST 32'h0000_0000

`endif

// ==== include/pin_function_select_pkg.sv ====
// Types shared by the pin-select logic
package pin_function_select_pkg;

	// Selection codes; every other value is reserved
	typedef enum logic [3:0] {
		code_base = 4'h0,
		code_alt1 = 4'h1,
		code_alt2 = 4'h2,
		code_alt4 = 4'h4,
		code_alt8 = 4'h8
	} sel_code_t;

	// Bus slave states, one-hot
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_access = 2'b10
	} apb_state_t;

	typedef logic [3:0] field_t;

	// Function slots per pin: code 0, 1h, 2h, 4h, 8h
	localparam int SLOT_N = 5;

endpackage

// ==== include/field_if.sv ====
// Carrier between a selection field and the pin it steers
`timescale 1ns/1ns
interface field_if;
	import pin_function_select_pkg::*;
	field_t code;
	logic reserved;
	modport holder (output code, input reserved);
	modport user (input code, output reserved);
endinterface

// ==== src/sel_field_reg.sv ====
// One software-written 4-bit selection field
`timescale 1ns/1ns
`include "pin_function_select_regs.svh"
module sel_field_reg
	import pin_function_select_pkg::*;
#(
	parameter field_t RESET_VAL = `SEL_FIELD_RST
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic wr_en,
	input wire logic [3:0] wr_data,
	field_if.holder f
);

	field_t code_q;

	// Stored code; reserved values are kept so software reads them back
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			code_q <= RESET_VAL;
		end else if (wr_en) begin
			code_q <= wr_data;
		end
	end

	assign f.code = code_q;

endmodule

// ==== src/pin_route_cell.sv ====
// Routing of one pad to one of its five function slots
`timescale 1ns/1ns
module pin_route_cell
	import pin_function_select_pkg::*;
#(
	parameter bit HAS_BASE = 1'b0
) (
	input wire logic core_clk,
	input wire logic reset,
	field_if.user f,
	input wire logic pad_sense,
	input wire logic [SLOT_N-1:0] func_drive,
	input wire logic [SLOT_N-1:0] func_oe,
	output logic pad_drive_q,
	output logic pad_oe_q,
	output logic [SLOT_N-1:0] func_sense_q
);

	logic [SLOT_N-1:0] hot;
	logic pad_drive_d;
	logic pad_oe_d;
	logic [SLOT_N-1:0] func_sense_d;

	// Slot decode; code 0 is a function only on pins that have one
	assign hot[0] = HAS_BASE && (f.code == code_base);
	assign hot[1] = (f.code == code_alt1);
	assign hot[2] = (f.code == code_alt2);
	assign hot[3] = (f.code == code_alt4);
	assign hot[4] = (f.code == code_alt8);
	// No slot hit: pad stays undriven, all function inputs held low
	assign f.reserved = ~|hot && (f.code != code_base); // R11

	assign pad_drive_d = |(hot & func_drive);
	assign pad_oe_d = |(hot & func_oe); // R11
	assign func_sense_d = hot & {SLOT_N{pad_sense}};

	// Registered pad side; follows the stored code one cycle later
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pad_drive_q <= 1'b0;
			pad_oe_q <= 1'b0;
			func_sense_q <= '0;
		end else begin
			pad_drive_q <= pad_drive_d; // R12
			pad_oe_q <= pad_oe_d; // R12
			func_sense_q <= func_sense_d;
		end
	end

endmodule

// ==== src/pin_function_select_fields.sv ====
// Pin-function selection for nine pads with an APB register slave
`timescale 1ns/1ns
`include "pin_function_select_regs.svh"
module pin_function_select_fields
	import pin_function_select_pkg::*;
#(
	parameter int ADDR_W = 12,
	parameter int NPIN = 9
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NPIN-1:0] pad_sense,
	output logic [NPIN-1:0] pad_drive,
	output logic [NPIN-1:0] pad_oe,
	input wire logic [NPIN*SLOT_N-1:0] func_drive,
	input wire logic [NPIN*SLOT_N-1:0] func_oe,
	output logic [NPIN*SLOT_N-1:0] func_sense
);

	// ----------------------------------------------------------------
	// Pin and slot map
	// ----------------------------------------------------------------
	// Function slot s of pin p sits at bit p*5+s of func_drive,
	// func_oe and func_sense. Slots are codes 0, 1h, 2h, 4h, 8h.
	// Pin 0, word two 19:16:
	//   0 none, 1 audio_serial_lane_3, 2 sport0_tx_frame_sync,
	//   3 gpio_bank1_bit11, 4 MII transmit data bit 3
	// Pin 1, word two 15:12:
	//   0 none, 1 audio_serial_lane_4, 2 sport0_rx_frame_sync,
	//   3 gpio_bank1_bit12, 4 MII collision input
	// Pin 2, word two 11:8:
	//   0 none, 1 audio_serial_lane_5, 2 sport0_tx_clock,
	//   3 gpio_bank1_bit13, 4 MII transmit clock
	// Pin 3, word two 7:4:
	//   0 realtime_unit0_input_bit6, 1 audio_serial_lane_6,
	//   2 sport0_rx_clock, 3 gpio_bank1_bit14, 4 MII transmit enable
	// Pin 4, word two 3:0:
	//   0 realtime_unit0_input_bit7, 1 audio_serial_lane_7,
	//   2 pwm1_trip_zone0, 3 realtime_unit0_output_bit17,
	//   4 gpio_bank1_bit15
	// Pin 5, word three 31:28:
	//   0 sata_cold_presence_detect, 1 spi0_chip_select2,
	//   2 uart0_request_to_send, 3 gpio_bank8_bit1, 4 MII rx data 0
	// Pin 6, word three 27:24:
	//   0 sata_mech_presence_switch, 1 spi0_chip_select3,
	//   2 uart0_clear_to_send, 3 gpio_bank8_bit2, 4 MII rx data 1
	// Pin 7, word three 23:20:
	//   0 none, 1 spi0_chip_select4, 2 uart0_transmit_out,
	//   3 gpio_bank8_bit3, 4 MII rx data 2
	// Pin 8, word three 19:16:
	//   0 none, 1 spi0_chip_select5, 2 uart0_receive_in,
	//   3 gpio_bank8_bit4, 4 MII rx data 3
	// A slot marked none never drives and never sees the pad.

	// ----------------------------------------------------------------
	// Field placement
	// ----------------------------------------------------------------
	localparam int FIELD_LSB [9] = '{
		`SEL2_19_16_LSB, `SEL2_15_12_LSB, `SEL2_11_8_LSB, // R1 R2 R3
		`SEL2_7_4_LSB, `SEL2_3_0_LSB, `SEL3_31_28_LSB, // R4 R5 R6
		`SEL3_27_24_LSB, `SEL3_23_20_LSB, `SEL3_19_16_LSB // R7 R8 R9
	};
	// Fields 5 to 8 live in word three
	localparam logic [8:0] IN_WORD3 = 9'b1_1110_0000;
	// Pins whose code 0 is a function rather than tri-state
	localparam logic [8:0] HAS_BASE = 9'b0_0111_1000; // R4 R5 R6 R7

	apb_state_t state_q;
	apb_state_t state_d;
	field_t codes [NPIN];
	logic [NPIN-1:0] rsvd;
	logic [31:0] rd_sel2;
	logic [31:0] rd_sel3;
	logic [31:0] rd_stat;
	logic [31:0] rd_mux;

	field_if fld [NPIN] ();

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Unmapped offsets answer with an error and change nothing
	wire hit2 = (paddr == `OFS_SEL2_WORD);
	wire hit3 = (paddr == `OFS_SEL3_WORD);
	wire hit_st = (paddr == `OFS_SEL_STATUS);
	wire mapped = hit2 || hit3 || hit_st;
	wire setup = psel && !penable && (state_q == st_idle);
	wire commit = (state_q == st_access) && psel && penable && pready;
	// Status word is read-only; writing it is ignored without error
	wire wr_commit = commit && pwrite && !pslverr;
	wire wr2 = wr_commit && hit2;
	wire wr3 = wr_commit && hit3; // R10

	// ----------------------------------------------------------------
	// Read data
	// ----------------------------------------------------------------
	// Fields outside this block read as zero
	assign rd_sel2 = {12'h000, codes[0], codes[1], codes[2],
		codes[3], codes[4]};
	assign rd_sel3 = {codes[5], codes[6], codes[7], codes[8],
		16'h0000}; // R10
	assign rd_stat = {23'h00_0000, rsvd}; // R11
	assign rd_mux = hit2 ? rd_sel2 :
		hit3 ? rd_sel3 :
		hit_st ? rd_stat : 32'h0000_0000;

	// ----------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------
	// Setup goes to access; the access edge with pready returns home
	always_comb begin
		case (state_q)
			st_idle: state_d = setup ? st_access : st_idle;
			st_access: state_d = commit ? st_idle : st_access;
			default: state_d = st_idle;
		endcase
	end

	// Answer is prepared in setup so every bus output is a flop
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			state_q <= st_idle;
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= `SEL_WORD_RST;
		end else begin
			state_q <= state_d;
			pready <= setup || (pready && !commit);
			if (setup) begin
				pslverr <= !mapped;
				prdata <= pwrite ? 32'h0000_0000 : rd_mux;
			end
		end
	end

	// ----------------------------------------------------------------
	// Fields and pads
	// ----------------------------------------------------------------
	// One stored field and one routing cell per pad
	for (genvar i = 0; i < NPIN; i++) begin : g_pin
		localparam int LSB = FIELD_LSB[i];
		wire wr_en = IN_WORD3[i] ? wr3 : wr2;

		sel_field_reg #(
			.RESET_VAL(`SEL_FIELD_RST)
		) u_field (
			.core_clk(core_clk),
			.reset(reset),
			.wr_en(wr_en),
			.wr_data(pwdata[LSB +: 4]),
			.f(fld[i])
		);

		pin_route_cell #(
			.HAS_BASE(HAS_BASE[i])
		) u_route (
			.core_clk(core_clk),
			.reset(reset),
			.f(fld[i]),
			.pad_sense(pad_sense[i]),
			.func_drive(func_drive[i*SLOT_N +: SLOT_N]),
			.func_oe(func_oe[i*SLOT_N +: SLOT_N]),
			.pad_drive_q(pad_drive[i]),
			.pad_oe_q(pad_oe[i]),
			.func_sense_q(func_sense[i*SLOT_N +: SLOT_N])
		);

		assign codes[i] = fld[i].code;
		assign rsvd[i] = fld[i].reserved;
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// Pin 0 on MII transmit data bit 3
	a_pin0_alt8: assert property ( // R1
		codes[0] == code_alt8 |=>
		pad_drive[0] == $past(func_drive[4]) &&
		pad_oe[0] == $past(func_oe[4]))
		else $error("pin 0 not routed to slot 8h");

	// Pin 1 on serial port receive frame sync, input path too
	a_pin1_alt2: assert property ( // R2
		codes[1] == code_alt2 |=>
		pad_oe[1] == $past(func_oe[7]) &&
		func_sense[7] == $past(pad_sense[1]) && !func_sense[9])
		else $error("pin 1 not routed to slot 2h");

	// Pin 2 tri-stated at code 0
	a_pin2_tristate: assert property ( // R3
		codes[2] == code_base |=> !pad_oe[2] && func_sense[14:10] == 5'h0)
		else $error("pin 2 not tri-stated at code 0");

	// Pin 3 code 0 reaches the realtime input
	a_pin3_base: assert property ( // R4
		codes[3] == code_base |=>
		func_sense[15] == $past(pad_sense[3]) &&
		pad_oe[3] == $past(func_oe[15]))
		else $error("pin 3 base function not routed");

	// Pin 4 code 4h is the realtime output
	a_pin4_alt4: assert property ( // R5
		codes[4] == code_alt4 |=>
		pad_drive[4] == $past(func_drive[23]) &&
		pad_oe[4] == $past(func_oe[23]))
		else $error("pin 4 not routed to slot 4h");

	// Pin 5 code 0 reaches the cold presence input
	a_pin5_base: assert property ( // R6
		codes[5] == code_base |=>
		func_sense[25] == $past(pad_sense[5]) && !func_sense[29])
		else $error("pin 5 base function not routed");

	// Pin 6 code 1h is chip select three
	a_pin6_alt1: assert property ( // R7
		codes[6] == code_alt1 |=>
		pad_drive[6] == $past(func_drive[31]) &&
		pad_oe[6] == $past(func_oe[31]))
		else $error("pin 6 not routed to slot 1h");

	// Pin 7 tri-stated at code 0
	a_pin7_tristate: assert property ( // R8
		codes[7] == code_base |=> !pad_oe[7] && func_sense[35] == 1'b0)
		else $error("pin 7 not tri-stated at code 0");

	// Pin 8 code 4h is gpio bank 8 bit 4
	a_pin8_alt4: assert property ( // R9
		codes[8] == code_alt4 |=>
		pad_oe[8] == $past(func_oe[43]) &&
		func_sense[43] == $past(pad_sense[8]))
		else $error("pin 8 not routed to slot 4h");

	// Word three write is stored, lower bits read zero
	a_word3_store: assert property ( // R10
		wr3 |=> codes[5] == $past(pwdata[31:28]) &&
		codes[8] == $past(pwdata[19:16]) && rd_sel3[15:0] == 16'h0000)
		else $error("word three field not stored");

	// Reserved code never drives the pad
	a_rsvd_quiet: assert property ( // R11
		rsvd != '0 |=> (pad_oe & $past(rsvd)) == '0)
		else $error("pad driven under reserved code");

	// Write takes effect on the pad one edge after the access edge
	a_sel_latency: assert property ( // R12
		wr2 && pwdata[19:16] == code_alt8 |=> ##1
		pad_oe[0] == $past(func_oe[4]))
		else $error("new selection late on pad");

	// Bus answers in the cycle after setup
	a_apb_answer: assert property (
		setup |=> pready && penable ##1 !pready)
		else $error("bus answer not one cycle after setup");

	// Word two write is stored, upper bits read zero
	a_word2_store: assert property ( // R1
		wr2 |=> codes[0] == $past(pwdata[19:16]) &&
		codes[4] == $past(pwdata[3:0]) && rd_sel2[31:20] == 12'h000)
		else $error("word two field not stored");

	// Pin 0 code 1h is audio serial lane 3
	a_pin0_alt1: assert property ( // R1
		codes[0] == code_alt1 |=>
		pad_drive[0] == $past(func_drive[1]) &&
		pad_oe[0] == $past(func_oe[1]))
		else $error("pin 0 not routed to slot 1h");

	// Pin 4 code 0 reaches the second realtime input
	a_pin4_base: assert property ( // R5
		codes[4] == code_base |=>
		func_sense[20] == $past(pad_sense[4]) &&
		pad_drive[4] == $past(func_drive[20]))
		else $error("pin 4 base function not routed");

	// Pin 7 code 2h is the uart transmit output
	a_pin7_alt2: assert property ( // R8
		codes[7] == code_alt2 |=>
		pad_drive[7] == $past(func_drive[37]) &&
		pad_oe[7] == $past(func_oe[37]))
		else $error("pin 7 not routed to slot 2h");

	// Pin 8 tri-stated at code 0, no function sees it
	a_pin8_tristate: assert property ( // R9
		codes[8] == code_base |=>
		!pad_oe[8] && func_sense[44:40] == 5'h00)
		else $error("pin 8 not tri-stated at code 0");

	// Unmapped offset answers with an error
	a_unmapped_err: assert property (
		setup && !mapped |=> pready && pslverr)
		else $error("unmapped offset not refused");

	// Refused transfer leaves every field as it was
	a_refused_keep: assert property ( // R10
		commit && pslverr |=> $stable(rd_sel2) && $stable(rd_sel3))
		else $error("refused transfer changed a field");

	// Write transfers return zero read data
	a_write_rdata: assert property (
		setup && pwrite |=> prdata == 32'h0000_0000)
		else $error("write transfer returned read data");

endmodule

// ==== bench/tb.sv ====
// Self-checking bench for the nine-pad function select block
`timescale 1ns/1ns
`include "pin_function_select_regs.svh"
module tb;
	import pin_function_select_pkg::*;
	localparam int NP = 9;
	localparam int NF = NP * SLOT_N;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [NP-1:0] pad_sense = '0;
	logic [NP-1:0] pad_drive;
	logic [NP-1:0] pad_oe;
	logic [NF-1:0] func_drive = '0;
	logic [NF-1:0] func_oe = '0;
	logic [NF-1:0] func_sense;
	int failures = 0;
	int cmp_count = 0;
	integer seed = 32'h0095_3bdc;
	field_t cur [NP];
	logic [31:0] rd;
	logic err;

	// 8 ns period
	always #4 core_clk = ~core_clk;

	pin_function_select_fields #(.ADDR_W(12), .NPIN(NP)) DUT (
		.core_clk(core_clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pad_sense(pad_sense),
		.pad_drive(pad_drive), .pad_oe(pad_oe),
		.func_drive(func_drive), .func_oe(func_oe),
		.func_sense(func_sense)
	);

	// ----------------------------------------------------------------
	// Reference model
	// ----------------------------------------------------------------
	// Pins 0..4 sit in word two, 5..8 in word three
	function automatic int lsb_of(int p);
		return p < 5 ? 16 - 4 * p : 28 - 4 * (p - 5);
	endfunction

	// Code 0 is a function only on pins 3..6
	function automatic int slot_of(int p, field_t c);
		case (c)
			4'h0: return (p >= 3 && p <= 6) ? 0 : -1;
			4'h1: return 1;
			4'h2: return 2;
			4'h4: return 3;
			4'h8: return 4;
			default: return -1;
		endcase
	endfunction

	function automatic logic [31:0] word_of(int w);
		logic [31:0] v = 32'h0000_0000;
		for (int p = 0; p < NP; p++) begin
			if ((p < 5) == (w == 2)) begin
				v[lsb_of(p) +: 4] = cur[p];
			end
		end
		return v;
	endfunction

	function automatic logic [31:0] stat_of();
		logic [31:0] v = 32'h0000_0000;
		for (int p = 0; p < NP; p++) begin
			v[p] = !(cur[p] inside {4'h0, 4'h1, 4'h2, 4'h4, 4'h8});
		end
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Compare, bus and closing tasks
	// ----------------------------------------------------------------
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk_word(logic [31:0] got, logic [31:0] exp, string s);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s %h not %h", $time, s, got, exp);
		end
	endtask

	task automatic chk_pad(logic [NF-1:0] got, logic [NF-1:0] exp, string s);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("unexpected at %0t: %s %h not %h", $time, s, got, exp);
		end
	endtask

	// One transfer; the bound on the wait ends a hung slave
	task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
		int n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			failures++;
			$display("unexpected at %0t: no pready", $time);
			wrap_up();
		end
	endtask

	// Fresh random pad traffic, checked exactly one edge later
	task automatic check_pads();
		logic [63:0] r1 = {$random(seed), $random(seed)};
		logic [63:0] r2 = {$random(seed), $random(seed)};
		logic [NF-1:0] ed = '0;
		logic [NF-1:0] eo = '0;
		logic [NF-1:0] es = '0;
		int s;
		func_drive <= r1[NF-1:0];
		func_oe <= r2[NF-1:0];
		pad_sense <= r2[63:55];
		@(posedge core_clk);
		#1;
		for (int p = 0; p < NP; p++) begin
			s = slot_of(p, cur[p]);
			if (s >= 0) begin
				ed[p] = r1[p * SLOT_N + s];
				eo[p] = r2[p * SLOT_N + s];
				es[p * SLOT_N + s] = r2[55 + p];
			end
		end
		chk_pad(NF'(pad_drive), ed, "pad_drive");
		chk_pad(NF'(pad_oe), eo, "pad_oe");
		chk_pad(func_sense, es, "func_sense");
	endtask

	task automatic set_words(logic [31:0] w2, logic [31:0] w3);
		for (int p = 0; p < NP; p++) begin
			cur[p] = p < 5 ? w2[lsb_of(p) +: 4] : w3[lsb_of(p) +: 4];
		end
		apb(1'b1, `OFS_SEL2_WORD, w2);
		apb(1'b1, `OFS_SEL3_WORD, w3);
		check_pads();
		apb(1'b0, `OFS_SEL2_WORD, 32'h0000_0000);
		chk_word(rd, word_of(2), "word two");
		apb(1'b0, `OFS_SEL3_WORD, 32'h0000_0000);
		chk_word(rd, word_of(3), "word three");
		apb(1'b0, `OFS_SEL_STATUS, 32'h0000_0000);
		chk_word(rd, stat_of(), "status");
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		foreach (cur[p]) cur[p] = 4'h0;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		apb(1'b0, `OFS_SEL3_WORD, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000, "word three reset");
		check_pads();
		$display("test reset done");
		// Same code in every field, reserved ones included
		for (int c = 0; c < 16; c++) begin
			set_words({8{4'(c)}}, {8{4'(c)}});
		end
		$display("test all codes done");
		// Random words with a corner mix of reserved and base codes
		set_words(32'hFFF3_0480, 32'h0900_5555);
		repeat (24) set_words($random(seed), $random(seed));
		$display("test random done");
		// Unmapped place refused; status write ignored
		apb(1'b0, 12'h004, 32'h0000_0000);
		chk_word(32'(err), 32'h0000_0001, "unmapped err");
		chk_word(rd, 32'h0000_0000, "unmapped data");
		apb(1'b1, 12'h014, 32'hFFFF_FFFF);
		chk_word(32'(err), 32'h0000_0001, "unmapped write err");
		apb(1'b1, `OFS_SEL_STATUS, 32'hFFFF_FFFF);
		chk_word(32'(err), 32'h0000_0000, "status write err");
		apb(1'b0, `OFS_SEL3_WORD, 32'h0000_0000);
		chk_word(rd, word_of(3), "word kept");
		apb(1'b0, `OFS_SEL_STATUS, 32'h0000_0000);
		chk_word(rd, stat_of(), "status kept");
		$display("test refusals done");
		// Reset in mid-run clears every field
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		foreach (cur[p]) cur[p] = 4'h0;
		apb(1'b0, `OFS_SEL3_WORD, 32'h0000_0000);
		chk_word(rd, 32'h0000_0000, "word three rerun");
		check_pads();
		$display("test second reset done");
		wrap_up();
	end
endmodule
